//--- hw/output_driver_cfg.svh
`ifndef OUTPUT_DRIVER_CFG_SVH
`define OUTPUT_DRIVER_CFG_SVH

// ==========================================
// Register port widths
`define REG_ADDR_W       11
`define REG_DATA_W       16

// ==========================================
// Register offsets
`define SPK_BOOST_OFS    11'h025
`define LINE_FB_OFS      11'h037
`define LINE_VMID_OFS    11'h038
`define PIN_PULL_OFS     11'h721
`define OUT_ENA_OFS      11'h001
`define CLK_CFG_OFS      11'h002
`define LINE_CFG_OFS     11'h003
`define STATUS_OFS       11'h004

// ==========================================
// Field positions
`define L_BOOST_MSB      5
`define L_BOOST_LSB      3
`define R_BOOST_MSB      2
`define R_BOOST_LSB      0
`define PULLUP_BIT       1
`define VMID_BUF_BIT     7
`define FB_ONE_BIT       7
`define FB_TWO_BIT       6
`define ENA_SPK_L_BIT    0
`define ENA_SPK_R_BIT    1
`define ENA_EP_IN_BIT    2
`define ENA_EP_OUT_BIT   3
`define ENA_SRC_SEL_BIT  4
`define CFG_SE_ONE_BIT   0
`define CFG_SE_TWO_BIT   1
`define CFG_L_P1P_BIT    2
`define CFG_R_P1N_BIT    3

// ==========================================
// Reset values
`define BOOST_RST        3'h0
`define PULLUP_RST       1'h1
`define BIT_RST          1'h0
`define RATE_RST         4'h0

// ==========================================
// Encodings of rate and ratio fields
`define SR_8K            4'h0
`define SR_11K           4'h1
`define SR_12K           4'h2
`define SR_16K           4'h3
`define SR_22K           4'h4
`define SR_24K           4'h5
`define SR_32K           4'h6
`define SR_44K           4'h7
`define SR_48K           4'h8
`define SR_88K           4'h9
`define SR_96K           4'ha
`define RT_128           4'h0
`define RT_192           4'h1
`define RT_256           4'h2
`define RT_384           4'h3
`define RT_512           4'h4
`define RT_768           4'h5
`define RT_1024          4'h6
`define RT_1536          4'h7

// ==========================================
// Timing (clock and switching rates in units of 0.1 kHz)
`define CLK_PERIOD_NS    4
`define CORE_KHZ10       2500000
`define F256_KHZ10       2560
`define F341_KHZ10       3413
`define F353_KHZ10       3528
`define F384_KHZ10       3840
`define HALF_256         (`CORE_KHZ10 / (2 * `F256_KHZ10))
`define HALF_341         (`CORE_KHZ10 / (2 * `F341_KHZ10))
`define HALF_353         (`CORE_KHZ10 / (2 * `F353_KHZ10))
`define HALF_384         (`CORE_KHZ10 / (2 * `F384_KHZ10))
`define HALF_W           10
`define CLK_ABSENT_NS    2000
`define CLK_ABSENT_CYC   (`CLK_ABSENT_NS / `CLK_PERIOD_NS)
`define MON_W            10

`endif

//--- hw/output_driver_pkg.sv
package output_driver_pkg;

   // ==========================================
   // Switching frequency choice
   typedef enum logic [4:0] {
      FREQ_NONE = 5'b00001,
      FREQ_256  = 5'b00010,
      FREQ_341  = 5'b00100,
      FREQ_353  = 5'b01000,
      FREQ_384  = 5'b10000
   } sw_freq_e;

   // ==========================================
   // Speaker drive bundle
   typedef struct packed {
      logic       left_spk_out_en;
      logic       right_spk_out_en;
      logic       mono_mode;
      logic [2:0] left_spk_gain_step;
      logic [2:0] right_spk_gain_step;
   } spk_drive_s;

   // ==========================================
   // Line output bundle
   typedef struct packed {
      logic line_pair_one_single_ended;
      logic line_pair_two_single_ended;
      logic left_mix_to_pair_one_pos;
      logic right_mix_to_pair_one_neg;
      logic line_pair_one_gnd_feedback_en;
      logic line_pair_two_gnd_feedback_en;
      logic line_midref_buffer_en;
   } line_cfg_s;

endpackage : output_driver_pkg

//--- hw/classd_clk_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "output_driver_cfg.svh"

module classd_clk_gen (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 run,
   input  wire logic [`HALF_W-1:0]   half_cnt,
   output logic                      sw_clk_r
);

   logic [`HALF_W-1:0] cnt_r;
   logic [`HALF_W-1:0] cnt_nxt;
   logic               wrap;

   // Half period reached; >= keeps a rate change mid-run safe
   assign wrap    = (cnt_r >= (half_cnt - `HALF_W'd1));
   assign cnt_nxt = wrap ? '0 : cnt_r + `HALF_W'd1;

   // Divider, held low while stopped
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         cnt_r    <= '0;
         sw_clk_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (wrap) begin
            sw_clk_r <= ~sw_clk_r;
         end
      end
   end

endmodule : classd_clk_gen
`default_nettype wire

//--- hw/output_driver_control.sv
// Overview of operation
// [RULE1] Left boost is bits 5:3, 0 to +9 dB in 1.5 dB steps, 111 gives +12 dB, reset 000.
// [RULE2] Right boost is bits 2:0 of the same register, same coding, reset 000.
// [RULE3] Software keeps both boost fields fixed while a speaker is enabled.
// [RULE4] Bit 1 of the pull control register enables the speaker-mode pin pull-up and resets to 1.
// [RULE5] The switching clock runs while either speaker enable is set, else it stops; here it also stops while clk_ok is low.
// [RULE6] Source select 0 takes port one rate and ratio for the divider, 1 takes port two.
// [RULE7] The 44.1 kHz family gives 352.8 kHz and the 12/24/48/96 kHz family gives 384 kHz.
// [RULE8] 8 kHz gives 341.3 kHz at 256/512/1024 else 256; 16/32 kHz 341.3 at 128/256/512 else 384.
// [RULE9] Both speakers are forced off while the selected clock is absent.
// [RULE10] Software enables the earpiece input stage at least 50 us before the output stage.
// [RULE11] Software sets the VMID buffer enable (bit 7, reset 0) while a pair is single-ended.
// [RULE12] Bit 7 of the feedback register enables pair one ground-loop feedback, reset 0.
// [RULE13] Bit 6 of that register enables pair two ground-loop feedback, reset 0.
// [RULE14] Software enables ground-loop feedback only on single-ended pairs.
// [RULE15] Pair mode 1 is single-ended with mixer routes to its legs, 0 is differential.
// [RULE16] A high speaker-mode pin selects mono speakers, low selects stereo.
// [RULE17] Registers are 16 bits, undefined bits read zero and ignore writes, writes act next edge.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "output_driver_cfg.svh"

module output_driver_control (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic [`REG_ADDR_W-1:0]   reg_addr,
   input  wire logic [`REG_DATA_W-1:0]   reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [`REG_DATA_W-1:0]   reg_rdata,
   input  wire logic                     spk_mono_select_pin,
   input  wire logic                     port_one_clock,
   input  wire logic                     port_two_clock,
   output output_driver_pkg::spk_drive_s spk_drive,
   output logic                          spk_cfg_pin_pullup_en,
   output logic                          classd_sw_clk,
   output logic                          earpiece_input_stage_en,
   output logic                          earpiece_output_stage_en,
   output output_driver_pkg::line_cfg_s  line_cfg
);
   import output_driver_pkg::*;

   // ==========================================
   // Register state
   logic [2:0]  l_boost_r;
   logic [2:0]  r_boost_r;
   logic        pullup_r;
   logic        vmid_r;
   logic        fb_one_r;
   logic        fb_two_r;
   logic        spk_l_en_r;
   logic        spk_r_en_r;
   logic        ep_in_r;
   logic        ep_out_r;
   logic        src_sel_r;
   logic [3:0]  sr_one_r;
   logic [3:0]  rt_one_r;
   logic [3:0]  sr_two_r;
   logic [3:0]  rt_two_r;
   logic        se_one_r;
   logic        se_two_r;
   logic        l_p1p_r;
   logic        r_p1n_r;
   logic [15:0] rdata_r;

   // Clock monitor state
   logic              sel_prev_r;
   logic [`MON_W-1:0] idle_r;
   logic [`MON_W-1:0] idle_nxt;
   logic              present_r;

   // Output flops
   spk_drive_s  spk_r;
   line_cfg_s   line_r;
   logic        run_r;

   // ==========================================
   // Address decode
   wire wr_boost = reg_wr && (reg_addr == `SPK_BOOST_OFS);
   wire wr_fb    = reg_wr && (reg_addr == `LINE_FB_OFS);
   wire wr_vmid  = reg_wr && (reg_addr == `LINE_VMID_OFS);
   wire wr_pull  = reg_wr && (reg_addr == `PIN_PULL_OFS);
   wire wr_ena   = reg_wr && (reg_addr == `OUT_ENA_OFS);
   wire wr_ccfg  = reg_wr && (reg_addr == `CLK_CFG_OFS);
   wire wr_lcfg  = reg_wr && (reg_addr == `LINE_CFG_OFS);

   // ==========================================
   // Rate selection and divider lookup
   // [RULE6] source picks settings
   wire [3:0] sel_sr = src_sel_r ? sr_two_r : sr_one_r;
   wire [3:0] sel_rt = src_sel_r ? rt_two_r : rt_one_r;

   // Unsupported rate/ratio pairs give no clock
   function automatic sw_freq_e pick_freq(input logic [3:0] sr, input logic [3:0] rt);
      logic [3:0] max_rt;
      logic       low;
      max_rt = `RT_128;
      low = (rt == `RT_256) || (rt == `RT_512) || (rt == `RT_1024) || (rt == `RT_128);
      case (sr)
         `SR_8K:  max_rt = `RT_1536;
         `SR_11K: max_rt = `RT_1024;
         `SR_12K: max_rt = `RT_1024;
         `SR_16K: max_rt = `RT_768;
         `SR_22K: max_rt = `RT_512;
         `SR_24K: max_rt = `RT_512;
         `SR_32K: max_rt = `RT_384;
         `SR_44K: max_rt = `RT_256;
         `SR_48K: max_rt = `RT_256;
         default: max_rt = `RT_128;
      endcase
      if (sr > `SR_96K || rt > max_rt) begin
         pick_freq = FREQ_NONE;
      end else begin
         case (sr)
            // [RULE8] 8 kHz column
            `SR_8K: pick_freq = (low && rt != `RT_128) ? FREQ_341 : FREQ_256;
            // [RULE8] 16 and 32 kHz
            `SR_16K,
            `SR_32K: pick_freq = low ? FREQ_341 : FREQ_384;
            // [RULE7] 44.1 kHz family
            `SR_11K,
            `SR_22K,
            `SR_44K,
            `SR_88K: pick_freq = FREQ_353;
            // [RULE7] 48 kHz family
            default: pick_freq = FREQ_384;
         endcase
      end
   endfunction : pick_freq

   wire sw_freq_e freq = pick_freq(sel_sr, sel_rt);

   // Half-period count per frequency
   logic [`HALF_W-1:0] half_cnt;
   always_comb begin
      case (freq)
         FREQ_256: half_cnt = `HALF_W'(`HALF_256);
         FREQ_341: half_cnt = `HALF_W'(`HALF_341);
         FREQ_353: half_cnt = `HALF_W'(`HALF_353);
         default:  half_cnt = `HALF_W'(`HALF_384);
      endcase
   end

   // ==========================================
   // Clock presence monitor
   wire sel_clk  = src_sel_r ? port_two_clock : port_one_clock;
   wire sel_edge = sel_clk ^ sel_prev_r;
   wire idle_top = (idle_r >= `MON_W'(`CLK_ABSENT_CYC));
   assign idle_nxt = sel_edge ? '0 : (idle_top ? idle_r : idle_r + `MON_W'd1);

   // [RULE9] watch selected clock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_prev_r <= 1'b0;
         idle_r     <= '0;
         present_r  <= 1'b0;
      end else begin
         sel_prev_r <= sel_clk;
         idle_r     <= idle_nxt;
         present_r  <= (idle_nxt < `MON_W'(`CLK_ABSENT_CYC));
      end
   end

   // [RULE9] speakers gated by clock
   wire clk_ok = present_r && (freq != FREQ_NONE);
   // [RULE5] run on either enable
   wire run_nxt = (spk_l_en_r || spk_r_en_r) && clk_ok;

   // ==========================================
   // Register writes
   // [RULE17] writes land next edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         l_boost_r  <= `BOOST_RST;
         r_boost_r  <= `BOOST_RST;
         pullup_r   <= `PULLUP_RST;
         vmid_r     <= `BIT_RST;
         fb_one_r   <= `BIT_RST;
         fb_two_r   <= `BIT_RST;
      end else begin
         if (wr_boost) begin
            // [RULE1] left boost field
            l_boost_r <= reg_wdata[`L_BOOST_MSB:`L_BOOST_LSB];
            // [RULE2] right boost field
            r_boost_r <= reg_wdata[`R_BOOST_MSB:`R_BOOST_LSB];
         end
         // [RULE4] pin pull-up bit
         if (wr_pull) pullup_r <= reg_wdata[`PULLUP_BIT];
         if (wr_vmid) vmid_r <= reg_wdata[`VMID_BUF_BIT];
         if (wr_fb) begin
            // [RULE12] pair one feedback
            fb_one_r <= reg_wdata[`FB_ONE_BIT];
            // [RULE13] pair two feedback
            fb_two_r <= reg_wdata[`FB_TWO_BIT];
         end
      end
   end

   // Enables and line setup
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         spk_l_en_r <= `BIT_RST;
         spk_r_en_r <= `BIT_RST;
         ep_in_r    <= `BIT_RST;
         ep_out_r   <= `BIT_RST;
         src_sel_r  <= `BIT_RST;
         sr_one_r   <= `RATE_RST;
         rt_one_r   <= `RATE_RST;
         sr_two_r   <= `RATE_RST;
         rt_two_r   <= `RATE_RST;
         se_one_r   <= `BIT_RST;
         se_two_r   <= `BIT_RST;
         l_p1p_r    <= `BIT_RST;
         r_p1n_r    <= `BIT_RST;
      end else begin
         if (wr_ena) begin
            spk_l_en_r <= reg_wdata[`ENA_SPK_L_BIT];
            spk_r_en_r <= reg_wdata[`ENA_SPK_R_BIT];
            ep_in_r    <= reg_wdata[`ENA_EP_IN_BIT];
            ep_out_r   <= reg_wdata[`ENA_EP_OUT_BIT];
            src_sel_r  <= reg_wdata[`ENA_SRC_SEL_BIT];
         end
         if (wr_ccfg) begin
            sr_one_r <= reg_wdata[3:0];
            rt_one_r <= reg_wdata[7:4];
            sr_two_r <= reg_wdata[11:8];
            rt_two_r <= reg_wdata[15:12];
         end
         if (wr_lcfg) begin
            // [RULE15] pair mode and routes
            se_one_r <= reg_wdata[`CFG_SE_ONE_BIT];
            se_two_r <= reg_wdata[`CFG_SE_TWO_BIT];
            l_p1p_r  <= reg_wdata[`CFG_L_P1P_BIT];
            r_p1n_r  <= reg_wdata[`CFG_R_P1N_BIT];
         end
      end
   end

   // ==========================================
   // Read-back mux, undefined bits zero
   logic [15:0] rd_val;
   always_comb begin
      rd_val = 16'h0000;
      case (reg_addr)
         `SPK_BOOST_OFS: rd_val = {10'h000, l_boost_r, r_boost_r};
         `LINE_FB_OFS:   rd_val = {8'h00, fb_one_r, fb_two_r, 6'h00};
         `LINE_VMID_OFS: rd_val = {8'h00, vmid_r, 7'h00};
         `PIN_PULL_OFS:  rd_val = {14'h0000, pullup_r, 1'b0};
         `OUT_ENA_OFS:   rd_val = {11'h000, src_sel_r, ep_out_r, ep_in_r,
                                   spk_r_en_r, spk_l_en_r};
         `CLK_CFG_OFS:   rd_val = {rt_two_r, sr_two_r, rt_one_r, sr_one_r};
         `LINE_CFG_OFS:  rd_val = {12'h000, r_p1n_r, l_p1p_r, se_two_r, se_one_r};
         `STATUS_OFS:    rd_val = {8'h00, 3'h0, freq == FREQ_NONE,
                                   spk_mono_select_pin, present_r, clk_ok, run_r};
         default:        rd_val = 16'h0000;
      endcase
   end

   // Read data for one cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= 16'h0000;
      end else begin
         rdata_r <= reg_rd ? rd_val : 16'h0000;
      end
   end

   // ==========================================
   // Output stage flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         spk_r  <= '0;
         line_r <= '0;
         run_r  <= 1'b0;
      end else begin
         run_r <= run_nxt;
         // [RULE9] force off without clock
         spk_r.left_spk_out_en  <= spk_l_en_r && clk_ok;
         spk_r.right_spk_out_en <= spk_r_en_r && clk_ok;
         // [RULE16] pin high means mono
         spk_r.mono_mode           <= spk_mono_select_pin;
         spk_r.left_spk_gain_step  <= l_boost_r;
         spk_r.right_spk_gain_step <= r_boost_r;
         line_r.line_pair_one_single_ended    <= se_one_r;
         line_r.line_pair_two_single_ended    <= se_two_r;
         // [RULE15] routes only in single-ended
         line_r.left_mix_to_pair_one_pos      <= l_p1p_r && se_one_r;
         line_r.right_mix_to_pair_one_neg     <= r_p1n_r && se_one_r;
         line_r.line_pair_one_gnd_feedback_en <= fb_one_r;
         line_r.line_pair_two_gnd_feedback_en <= fb_two_r;
         line_r.line_midref_buffer_en         <= vmid_r;
      end
   end

   // Earpiece enables and pin pull-up
   logic ep_in_q_r;
   logic ep_out_q_r;
   logic pullup_q_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ep_in_q_r  <= 1'b0;
         ep_out_q_r <= 1'b0;
         pullup_q_r <= `PULLUP_RST;
      end else begin
         ep_in_q_r  <= ep_in_r;
         ep_out_q_r <= ep_out_r;
         pullup_q_r <= pullup_r;
      end
   end

   // ==========================================
   // Switching clock divider
   // [RULE5] clock gated by enables
   classd_clk_gen u_clk_gen (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .run      (run_r),
      .half_cnt (half_cnt),
      .sw_clk_r (classd_sw_clk)
   );

   assign reg_rdata                = rdata_r;
   assign spk_drive                = spk_r;
   assign line_cfg                 = line_r;
   assign earpiece_input_stage_en  = ep_in_q_r;
   assign earpiece_output_stage_en = ep_out_q_r;
   assign spk_cfg_pin_pullup_en    = pullup_q_r;

endmodule : output_driver_control
`default_nettype wire

//--- dv/output_driver_control_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "output_driver_cfg.svh"

module output_driver_control_asserts (
   input wire logic                         clk,
   input wire logic                         sys_rst,
   input wire logic [`REG_ADDR_W-1:0]       reg_addr,
   input wire logic [`REG_DATA_W-1:0]       reg_wdata,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [`REG_DATA_W-1:0]       reg_rdata,
   input wire logic                         spk_mono_select_pin,
   input wire logic                         port_one_clock,
   input wire logic                         port_two_clock,
   input wire output_driver_pkg::spk_drive_s spk_drive,
   input wire logic                         spk_cfg_pin_pullup_en,
   input wire logic                         classd_sw_clk,
   input wire logic                         earpiece_input_stage_en,
   input wire logic                         earpiece_output_stage_en,
   input wire output_driver_pkg::line_cfg_s  line_cfg
);
   import output_driver_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ==========================================
   // Write and idle steps
   sequence wr_to(logic [`REG_ADDR_W-1:0] ofs);
      reg_wr && reg_addr == ofs;
   endsequence
   sequence spk_idle;
      !spk_drive.left_spk_out_en && !spk_drive.right_spk_out_en;
   endsequence

   // ==========================================
   // Register fields
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("rdata not idle");
   pull_read_a: assert property (reg_rd && reg_addr == `PIN_PULL_OFS |=>
      reg_rdata[15:2] == '0 && !reg_rdata[0]) else $error("pull bits set");
   pullup_follow_a: assert property (wr_to(`PIN_PULL_OFS) |-> ##2
      spk_cfg_pin_pullup_en == $past(reg_wdata[`PULLUP_BIT], 2)) else $error("pull-up stale");
   boost_follow_a: assert property (wr_to(`SPK_BOOST_OFS) |-> ##2
      spk_drive[5:0] == $past(reg_wdata[5:0], 2)) else $error("boost stale");
   fb_follow_a: assert property (wr_to(`LINE_FB_OFS) |-> ##2
      line_cfg[2:1] == $past(reg_wdata[7:6], 2)) else $error("fb stale");
   vmid_follow_a: assert property (wr_to(`LINE_VMID_OFS) |-> ##2
      line_cfg.line_midref_buffer_en == $past(reg_wdata[7], 2)) else $error("vmid stale");
   earpiece_follow_a: assert property (wr_to(`OUT_ENA_OFS) |-> ##2
      {earpiece_input_stage_en, earpiece_output_stage_en} == $past({reg_wdata[2],
      reg_wdata[3]}, 2)) else $error("earpiece stale");

   // ==========================================
   // Routing, mono, clock
   route_gate_a: assert property (line_cfg.left_mix_to_pair_one_pos ||
      line_cfg.right_mix_to_pair_one_neg |-> line_cfg.line_pair_one_single_ended)
      else $error("route in diff mode");
   mono_follow_a: assert property (!$past(sys_rst) |->
      spk_drive.mono_mode == $past(spk_mono_select_pin)) else $error("mono stale");
   clk_stop_a: assert property (spk_idle [*4] |-> !classd_sw_clk)
      else $error("sw clk runs idle");
endmodule : output_driver_control_asserts

bind output_driver_control output_driver_control_asserts output_driver_control_asserts_i (
   .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .spk_mono_select_pin(spk_mono_select_pin), .port_one_clock(port_one_clock),
   .port_two_clock(port_two_clock), .spk_drive(spk_drive),
   .spk_cfg_pin_pullup_en(spk_cfg_pin_pullup_en), .classd_sw_clk(classd_sw_clk),
   .earpiece_input_stage_en(earpiece_input_stage_en),
   .earpiece_output_stage_en(earpiece_output_stage_en), .line_cfg(line_cfg));
`default_nettype wire

//--- dv/test_output_driver_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "output_driver_cfg.svh"

module test_output_driver_control;
   import output_driver_pkg::*;
   localparam logic [`REG_ADDR_W-1:0] OFS [0:4] = '{`SPK_BOOST_OFS, `LINE_FB_OFS,
      `LINE_VMID_OFS, `PIN_PULL_OFS, 11'h7ff};
   localparam logic [15:0] MSK [0:4] = '{16'h003f, 16'h00c0, 16'h0080, 16'h0002, 16'h0000};
   localparam logic [15:0] RST [0:4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000};
   localparam logic [3:0]  MAX_RT [0:10] = '{4'h7, 4'h6, 4'h6, 4'h5, 4'h4, 4'h4, 4'h3,
      4'h2, 4'h2, 4'h0, 4'h0};
   logic                   clk;
   logic                   sys_rst;
   logic [`REG_ADDR_W-1:0] reg_addr = '0;
   logic [`REG_DATA_W-1:0] reg_wdata = '0;
   logic                   reg_wr = 1'b0;
   logic                   reg_rd = 1'b0;
   logic [`REG_DATA_W-1:0] reg_rdata;
   logic                   spk_mono_select_pin = 1'b0;
   logic                   port_one_clock = 1'b0;
   logic                   port_two_clock = 1'b0;
   spk_drive_s             spk_drive;
   logic                   spk_cfg_pin_pullup_en;
   logic                   classd_sw_clk;
   logic                   earpiece_input_stage_en;
   logic                   earpiece_output_stage_en;
   line_cfg_s              line_cfg;
   logic                   p1_run = 1'b0;
   logic                   p2_run = 1'b0;
   logic                   rd_d = 1'b0;
   logic [1:0]             div = 2'h0;
   logic [15:0]            exp_q [$];
   integer                 seed = 32'h67f0;
   integer                 err_count = 0;
   integer                 n_checks = 0;

   output_driver_control output_driver_control_i (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .spk_mono_select_pin(spk_mono_select_pin), .port_one_clock(port_one_clock),
      .port_two_clock(port_two_clock), .spk_drive(spk_drive),
      .spk_cfg_pin_pullup_en(spk_cfg_pin_pullup_en), .classd_sw_clk(classd_sw_clk),
      .earpiece_input_stage_en(earpiece_input_stage_en),
      .earpiece_output_stage_en(earpiece_output_stage_en), .line_cfg(line_cfg));

   // ==========================================
   // Clocks and read watcher
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Port clocks, frozen when stopped
   always @(posedge clk) begin
      div <= div + 2'h1;
      if (p1_run && div == 2'h3) port_one_clock <= ~port_one_clock;
      if (p2_run && div == 2'h3) port_two_clock <= ~port_two_clock;
   end
   // Read data against oldest note
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d) check("reg_rdata", exp_q.pop_front(), reg_rdata);
   end

   // ==========================================
   // Shared tasks
   task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wr(input logic [`REG_ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [`REG_ADDR_W-1:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   // Expected half period, 0 if unsupported
   function automatic int half_of(input logic [3:0] sr, input logic [3:0] rt);
      if (sr > 4'ha || rt > MAX_RT[sr]) return 0;
      if (sr == `SR_8K) return (rt == `RT_256 || rt == `RT_512 || rt == `RT_1024) ?
         `HALF_341 : `HALF_256;
      if (sr == `SR_16K || sr == `SR_32K) return rt[0] ? `HALF_384 : `HALF_341;
      if (sr == `SR_11K || sr == `SR_22K || sr == `SR_44K || sr == `SR_88K) return `HALF_353;
      return `HALF_384;
   endfunction : half_of
   // One high phase length
   task automatic meas(input int h);
      int n;
      n = 0;
      while (classd_sw_clk !== 1'b1 && n < 1200) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (classd_sw_clk === 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      check("sw_half", 16'(h), 16'(n));
   endtask : meas
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   // ==========================================
   // Scenarios
   initial begin
      logic [15:0] d;
      logic [3:0]  sr;
      logic [3:0]  rt;
      int          h;
      sys_rst = 1'b1;
      cyc(20);
      sys_rst <= 1'b0;
      check("pullup", 16'h1, 16'(spk_cfg_pin_pullup_en));
      check("spk_drive", 16'h0, 16'(spk_drive));
      check("line_cfg", 16'h0, 16'(line_cfg));
      for (int i = 0; i < 5; i++) rd(OFS[i], RST[i]);
      wr(`LINE_CFG_OFS, 16'h0003);
      // Ones, random, zeros
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 5; i++) begin
            d = (r == 0) ? 16'hffff : (r == 1) ? 16'($random(seed)) : 16'h0000;
            wr(OFS[i], d);
            rd(OFS[i], d & MSK[i]);
            cyc(2);
            case (i)
               0: check("boost", 16'(d[5:0]), 16'(spk_drive[5:0]));
               1: check("feedback", 16'(d[7:6]), 16'(line_cfg[2:1]));
               2: check("vmid", 16'(d[7]), 16'(line_cfg.line_midref_buffer_en));
               3: check("pullup", 16'(d[1]), 16'(spk_cfg_pin_pullup_en));
               default: ;
            endcase
         end
      end
      wr(`LINE_CFG_OFS, 16'h000d);
      cyc(2);
      check("line_cfg", 16'h0058, 16'(line_cfg));
      wr(`LINE_CFG_OFS, 16'h000e);
      cyc(2);
      check("line_cfg", 16'h0020, 16'(line_cfg));
      for (int m = 1; m >= 0; m--) begin
         spk_mono_select_pin <= 1'(m);
         cyc(3);
         check("mono", 16'(m), 16'(spk_drive.mono_mode));
      end
      // Divider per source, other port unsupported
      p1_run <= 1'b1;
      p2_run <= 1'b1;
      cyc(20);
      for (int k = 0; k < 6; k++) begin
         sr = (k == 4) ? 4'ha : (k == 0) ? `SR_8K : 4'({$random(seed)} % 11);
         rt = (k == 4) ? `RT_384 : (k == 0) ? `RT_1536 : 4'({$random(seed)} % 8);
         h = half_of(sr, rt);
         wr(`CLK_CFG_OFS, k[0] ? {rt, sr, 8'h7a} : {8'h7a, rt, sr});
         wr(`OUT_ENA_OFS, {11'h0, k[0], 4'h3});
         cyc(4);
         check("spk_en", 16'(h != 0), 16'(spk_drive.left_spk_out_en));
         meas(h);
         wr(`OUT_ENA_OFS, {11'h0, k[0], 4'h0});
         cyc(6);
         check("sw_stop", 16'h0, 16'(classd_sw_clk));
      end
      // Selected clock stops, then returns
      wr(`CLK_CFG_OFS, 16'h0008);
      wr(`OUT_ENA_OFS, 16'h0003);
      cyc(4);
      p1_run <= 1'b0;
      cyc(600);
      check("spk_absent", 16'h0, 16'(spk_drive[8:7]));
      check("sw_absent", 16'h0, 16'(classd_sw_clk));
      rd(`STATUS_OFS, 16'h0000);
      p1_run <= 1'b1;
      cyc(50);
      check("spk_back", 16'h3, 16'(spk_drive[8:7]));
      wr(`OUT_ENA_OFS, 16'h0004);
      cyc(12500);
      wr(`OUT_ENA_OFS, 16'h000c);
      cyc(2);
      check("earpiece", 16'h3, 16'({earpiece_input_stage_en, earpiece_output_stage_en}));
      summarize();
   end
   // Watchdog
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      summarize();
   end
endmodule : test_output_driver_control
`default_nettype wire
